//--- hw/sws_pkg.sv
// package: constants, register map and carrier types of the subtract / word store unit
package sws_pkg;
  localparam int XLEN = 64;
  localparam int PADDR_W = 36;
  localparam int WB_AW = 8;
  localparam int NREG = 32;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_OFFSET = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_VADDR_LO = 8'h10;
  localparam logic [7:0] ADR_VADDR_HI = 8'h14;
  localparam logic [7:0] ADR_GPR_LO = 8'h18;
  localparam logic [7:0] ADR_GPR_HI = 8'h1c;
  localparam logic [7:0] ADR_GPR_ACC = 8'h20;
  // control register fields
  localparam int CTRL_MODE64 = 0;
  localparam int CTRL_CPU_BE = 1;
  localparam int CTRL_MEM_BE = 2;
  localparam int CTRL_REV = 3;
  localparam int CTRL_COPEN_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DST_LSB = 3;
  localparam int CMD_SRCA_LSB = 8;
  localparam int CMD_SRCB_LSB = 13;
  localparam int CMD_COP_LSB = 18;
  localparam int ACC_WR_BIT = 5;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_EXC_LSB = 2;
  localparam logic [1:0] BYTE_CODE_WORD = 2'h3;
  localparam logic [1:0] COP_SYSTEM = 2'h0;
  localparam logic [1:0] COP_RESERVED = 2'h3;

  typedef enum logic [2:0] {OP_NONTRAPPING_SUBTRACT, OP_SUB, OP_SW, OP_SWC, OP_SWL} op_t;
  typedef enum logic [3:0] {
    EXC_NONE, EXC_OVF, EXC_ADDR, EXC_TLB_REFILL, EXC_TLB_INVALID, EXC_TLB_MOD,
    EXC_BUS, EXC_RESV, EXC_COP_UNUSABLE
  } exc_t;
  typedef enum logic [1:0] {XF_NONE, XF_REFILL, XF_INVALID, XF_MOD} xfault_t;

  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] vaddr;
  } xlat_req_t;
  typedef struct packed {
    logic ack;
    xfault_t fault;
    logic [PADDR_W-1:0] paddr;
  } xlat_rsp_t;
  typedef struct packed {
    logic valid;
    logic [PADDR_W-1:0] paddr;
    logic [XLEN-1:0] data;
    logic [1:0] byte_code;
  } mem_req_t;
  typedef struct packed {
    logic ack;
    logic bus_err;
  } mem_rsp_t;
endpackage : sws_pkg

//--- hw/gpr_mem.sv
// general register file storage with registered read data, entry zero reads as zero
`timescale 1ns/1ps
module gpr_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("gpr_mem: depth exceeds address range");
  end

  // entry zero is never written, so no reset of the array is needed
  always_ff @(posedge clk_i) begin
    if (we_i && waddr_i != '0) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // read data registered; zero forced for entry zero
  always_ff @(posedge clk_i) begin
    rdata_o <= (raddr_i == '0) ? '0 : mem[raddr_i];
  end
endmodule : gpr_mem

//--- hw/sub_store_exec.sv
// execution unit for non-trapping / trapping subtract and the word store group
// How it works
// - non-trapping subtract writes first source minus second source to destination
// - in 64-bit mode low 32 bits of difference are sign-extended
// - non-trapping subtract never raises integer overflow
// - trapping subtract overflows when carries out of 30 and 31 differ, no write
// - store address is base plus sign-extended 16-bit displacement
// - aligned word store writes second source word to the effective address
// - aligned word store raises address error when low two bits nonzero
// - coprocessor word store writes the word the coprocessor supplies
// - coprocessor word store to coprocessor zero is invalid
// - coprocessor word store raises address error when low two bits nonzero
// - coprocessor word store to coprocessor 3 is a reserved instruction
// - left partial store changes only the addressed word, one to four bytes
// - left partial store copies from register top byte down to memory low byte
// - left partial store never raises an alignment error
// - byte count code is low two address bits xor cpu big-endian flag
// - physical offset follows lane table; little-endian memory clears bits 1:0
// - lower or upper word lane chosen by address bit 2 xor cpu big-endian
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
module sub_store_exec #(
  parameter int ADDR_W = sws_pkg::WB_AW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output sws_pkg::xlat_req_t xlat_req_o,
  input wire sws_pkg::xlat_rsp_t xlat_rsp_i,
  output sws_pkg::mem_req_t mem_req_o,
  input wire sws_pkg::mem_rsp_t mem_rsp_i,
  output logic cop_req_o,
  output logic [1:0] cop_sel_o,
  input wire logic cop_ack_i,
  input wire logic [31:0] cop_data_i
);
  import sws_pkg::*;

  initial begin
    if (ADDR_W < 8) $error("sub_store_exec: address bus too narrow for the map");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_RDA, S_RDB, S_RDC, S_EXEC, S_COP, S_XLAT, S_STORE, S_WB
  } state_t;

  state_t state_reg;
  logic [7:0] ctrl_reg;
  logic [19:0] cmd_reg;
  logic [15:0] offset_reg;
  logic [XLEN-1:0] opa_reg, opb_reg, vaddr_reg, result_reg, stage_reg;
  logic [31:0] word_reg;
  exc_t exc_reg;
  logic done_reg, rd_pend_reg;
  logic [4:0] acc_idx_reg;
  logic [XLEN-1:0] rdata;
  logic [4:0] raddr;
  logic gpr_we;
  logic [4:0] gpr_waddr;
  logic [XLEN-1:0] gpr_wdata;

  op_t op;
  logic [4:0] dst, srca, srcb;
  logic [1:0] cop;
  logic mode64, cpu_be, mem_be, rev;
  logic [3:0] cop_en;
  logic [XLEN-1:0] ea, diff;
  logic sub_ovf;
  logic [1:0] lane_byte;
  logic lane_upper;
  logic [2:0] phys_off;
  logic wb_req, wb_wr, sw_acc_wr;

  // keeps the low word and sign-extends it from bit 31
  function automatic logic [XLEN-1:0] sext32(input logic [XLEN-1:0] v);
    sext32 = {{32{v[31]}}, v[31:0]};
  endfunction : sext32

  // merges write data into a 32-bit word under the byte selects
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  // command and control fields
  assign op = op_t'(cmd_reg[CMD_OP_LSB +: 3]);
  assign dst = cmd_reg[CMD_DST_LSB +: 5];
  assign srca = cmd_reg[CMD_SRCA_LSB +: 5];
  assign srcb = cmd_reg[CMD_SRCB_LSB +: 5];
  assign cop = cmd_reg[CMD_COP_LSB +: 2];
  assign mode64 = ctrl_reg[CTRL_MODE64];
  assign cpu_be = ctrl_reg[CTRL_CPU_BE];
  assign mem_be = ctrl_reg[CTRL_MEM_BE];
  assign rev = ctrl_reg[CTRL_REV];
  assign cop_en = ctrl_reg[CTRL_COPEN_LSB +: 4];

  // datapath arithmetic
  assign diff = opa_reg - opb_reg;
  assign ea = opa_reg + {{48{offset_reg[15]}}, offset_reg};
  // carry into bit 31 differing from carry out of bit 31 is two's complement overflow
  assign sub_ovf = (opa_reg[31] != opb_reg[31]) && (diff[31] != opa_reg[31]);

  // byte lane choice for the partial store, computed on the stored address
  assign lane_byte = vaddr_reg[1:0] ^ {2{cpu_be}};
  assign lane_upper = vaddr_reg[2] ^ cpu_be;
  // lane table: offset mirrors when cpu and memory order differ, then reverse order
  always_comb begin
    phys_off = xlat_rsp_i.paddr[2:0] ^ {3{rev}} ^ {3{cpu_be ^ mem_be}};
    if (!mem_be) begin
      phys_off[1:0] = 2'h0;
    end
  end

  // bus decode; read data launched on the request edge, writes land on the ack edge
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign sw_acc_wr = wb_wr && wb_adr_i[7:0] == ADR_GPR_ACC && state_reg == S_IDLE
                     && wb_sel_i[0];

  // register file read port: engine operands, otherwise software access
  always_comb begin
    case (state_reg)
      S_RDA: raddr = srca;
      S_RDB: raddr = srcb;
      // read port is registered, so a software read must present its index at once
      default: raddr = sw_acc_wr ? wb_dat_i[4:0] : acc_idx_reg;
    endcase
  end

  // single write port: engine result or software staging
  assign gpr_we = (state_reg == S_WB) || (sw_acc_wr && wb_dat_i[ACC_WR_BIT]);
  assign gpr_waddr = (state_reg == S_WB) ? dst : wb_dat_i[4:0];
  assign gpr_wdata = (state_reg == S_WB) ? result_reg : stage_reg;

  gpr_mem #(
    .WIDTH(XLEN),
    .DEPTH(NREG),
    .AW(5)
  ) u_gpr (
    .clk_i(clk_i),
    .we_i(gpr_we),
    .waddr_i(gpr_waddr),
    .wdata_i(gpr_wdata),
    .raddr_i(raddr),
    .rdata_o(rdata)
  );

  // bus acknowledge: one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // read data mux, unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req) begin
      case (wb_adr_i[7:0])
        ADR_CTRL: wb_dat_o <= {24'h0, ctrl_reg};
        ADR_CMD: wb_dat_o <= {12'h0, cmd_reg};
        ADR_OFFSET: wb_dat_o <= {16'h0, offset_reg};
        ADR_STATUS: wb_dat_o <= {26'h0, exc_reg, done_reg, state_reg != S_IDLE};
        ADR_VADDR_LO: wb_dat_o <= vaddr_reg[31:0];
        ADR_VADDR_HI: wb_dat_o <= vaddr_reg[63:32];
        ADR_GPR_LO: wb_dat_o <= stage_reg[31:0];
        ADR_GPR_HI: wb_dat_o <= stage_reg[63:32];
        ADR_GPR_ACC: wb_dat_o <= {27'h0, acc_idx_reg};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // software-writable control, displacement and command fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
      offset_reg <= 16'h0;
      cmd_reg <= 20'h0;
    end else if (wb_wr && state_reg == S_IDLE) begin
      case (wb_adr_i[7:0])
        ADR_CTRL: ctrl_reg <= 8'(merge({24'h0, ctrl_reg}, wb_dat_i, wb_sel_i));
        ADR_OFFSET: offset_reg <= 16'(merge({16'h0, offset_reg}, wb_dat_i, wb_sel_i));
        ADR_CMD: cmd_reg <= 20'(merge({12'h0, cmd_reg}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // staging words for register file access; a pending read overrides bus writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_reg <= '0;
      acc_idx_reg <= 5'h0;
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= sw_acc_wr && !wb_dat_i[ACC_WR_BIT];
      if (sw_acc_wr) begin
        acc_idx_reg <= wb_dat_i[4:0];
      end
      if (rd_pend_reg) begin
        stage_reg <= rdata;
      end else if (wb_wr && wb_adr_i[7:0] == ADR_GPR_LO) begin
        stage_reg[31:0] <= merge(stage_reg[31:0], wb_dat_i, wb_sel_i);
      end else if (wb_wr && wb_adr_i[7:0] == ADR_GPR_HI) begin
        stage_reg[63:32] <= merge(stage_reg[63:32], wb_dat_i, wb_sel_i);
      end
    end
  end

  // sequencer: operand fetch, execute, coprocessor, translate, store, write back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      opa_reg <= '0;
      opb_reg <= '0;
      vaddr_reg <= '0;
      result_reg <= '0;
      word_reg <= 32'h0;
      exc_reg <= EXC_NONE;
      done_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          // a command write starts the engine; done is cleared only by a new start
          if (wb_wr && wb_adr_i[7:0] == ADR_CMD) begin
            state_reg <= S_RDA;
            done_reg <= 1'b0;
            exc_reg <= EXC_NONE;
          end
        end
        S_RDA: state_reg <= S_RDB;
        S_RDB: begin
          opa_reg <= rdata;
          state_reg <= S_RDC;
        end
        S_RDC: begin
          opb_reg <= rdata;
          state_reg <= S_EXEC;
        end
        S_EXEC: begin
          vaddr_reg <= ea;
          word_reg <= opb_reg[31:0];
          state_reg <= S_IDLE;
          done_reg <= 1'b1;
          case (op)
            OP_NONTRAPPING_SUBTRACT: begin
              // no overflow check at all on this path
              result_reg <= mode64 ? sext32(diff) : {32'h0, diff[31:0]};
              state_reg <= S_WB;
              done_reg <= 1'b0;
            end
            OP_SUB: begin
              if (sub_ovf) begin
                exc_reg <= EXC_OVF;
              end else begin
                result_reg <= mode64 ? sext32(diff) : {32'h0, diff[31:0]};
                state_reg <= S_WB;
                done_reg <= 1'b0;
              end
            end
            OP_SW: begin
              if (ea[1:0] != 2'h0) begin
                exc_reg <= EXC_ADDR;
              end else begin
                state_reg <= S_XLAT;
                done_reg <= 1'b0;
              end
            end
            OP_SWC: begin
              // instruction validity outranks usability, usability outranks alignment
              if (cop == COP_SYSTEM || cop == COP_RESERVED) begin
                exc_reg <= EXC_RESV;
              end else if (!cop_en[cop]) begin
                exc_reg <= EXC_COP_UNUSABLE;
              end else if (ea[1:0] != 2'h0) begin
                exc_reg <= EXC_ADDR;
              end else begin
                state_reg <= S_COP;
                done_reg <= 1'b0;
              end
            end
            OP_SWL: begin
              state_reg <= S_XLAT;
              done_reg <= 1'b0;
            end
            default: exc_reg <= EXC_RESV;
          endcase
        end
        S_COP: begin
          if (cop_ack_i) begin
            word_reg <= cop_data_i;
            state_reg <= S_XLAT;
          end
        end
        S_XLAT: begin
          if (xlat_rsp_i.ack) begin
            case (xlat_rsp_i.fault)
              XF_REFILL: exc_reg <= EXC_TLB_REFILL;
              XF_INVALID: exc_reg <= EXC_TLB_INVALID;
              XF_MOD: exc_reg <= EXC_TLB_MOD;
              default: exc_reg <= EXC_NONE;
            endcase
            state_reg <= (xlat_rsp_i.fault == XF_NONE) ? S_STORE : S_IDLE;
            done_reg <= xlat_rsp_i.fault != XF_NONE;
          end
        end
        S_STORE: begin
          if (mem_rsp_i.ack) begin
            exc_reg <= mem_rsp_i.bus_err ? EXC_BUS : EXC_NONE;
            state_reg <= S_IDLE;
            done_reg <= 1'b1;
          end
        end
        S_WB: begin
          state_reg <= S_IDLE;
          done_reg <= 1'b1;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // translation request held from entry until the answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xlat_req_o <= '0;
    end else begin
      xlat_req_o.valid <= (state_reg == S_XLAT) ? !xlat_rsp_i.ack :
                          (state_reg == S_EXEC && (op == OP_SW || op == OP_SWL) &&
                           !(op == OP_SW && ea[1:0] != 2'h0)) ||
                          (state_reg == S_COP && cop_ack_i);
      if (state_reg == S_EXEC) begin
        xlat_req_o.vaddr <= ea;
      end
    end
  end

  logic [1:0] st_code;
  logic [31:0] st_word;
  // top register byte lands on the addressed byte, lower bytes follow downward
  assign st_code = (op == OP_SWL) ? lane_byte : BYTE_CODE_WORD;
  assign st_word = word_reg >> {(BYTE_CODE_WORD - st_code), 3'h0};

  // store request: partial word shifted to the addressed lane, whole word otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_o <= '0;
    end else if (state_reg == S_XLAT && xlat_rsp_i.ack && xlat_rsp_i.fault == XF_NONE) begin
      mem_req_o.valid <= 1'b1;
      mem_req_o.byte_code <= st_code;
      mem_req_o.paddr <= {xlat_rsp_i.paddr[PADDR_W-1:3], phys_off};
      mem_req_o.data <= lane_upper ? {st_word, 32'h0} : {32'h0, st_word};
    end else if (mem_rsp_i.ack) begin
      mem_req_o.valid <= 1'b0;
    end
  end

  // coprocessor word request held until the unit answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cop_req_o <= 1'b0;
      cop_sel_o <= 2'h0;
    end else begin
      cop_req_o <= (state_reg == S_EXEC && op == OP_SWC && cop != COP_SYSTEM &&
                    cop != COP_RESERVED && cop_en[cop] && ea[1:0] == 2'h0) ||
                   (cop_req_o && !cop_ack_i);
      cop_sel_o <= cop;
    end
  end

  // the extra condition rides inside the sequence, never beside it
  sequence s_exec(op_t o, logic c);
    state_reg == S_EXEC && op == o && c;
  endsequence

  property p_nontrapping_subtract_result;
    @(posedge clk_i) disable iff (rst_i)
      s_exec(OP_NONTRAPPING_SUBTRACT, mode64) |=> state_reg == S_WB && result_reg == sext32($past(diff));
  endproperty
  a_nontrapping_subtract_result: assert property (p_nontrapping_subtract_result) else $error("subtract result wrong");
  property p_nontrapping_subtract_noovf;
    @(posedge clk_i) disable iff (rst_i) s_exec(OP_NONTRAPPING_SUBTRACT, 1'b1) |=> ##1 exc_reg == EXC_NONE;
  endproperty
  a_nontrapping_subtract_noovf: assert property (p_nontrapping_subtract_noovf) else $error("subtract raised exception");
  property p_sub_trap;
    @(posedge clk_i) disable iff (rst_i)
      s_exec(OP_SUB, sub_ovf) |=> exc_reg == EXC_OVF && !gpr_we && state_reg == S_IDLE;
  endproperty
  a_sub_trap: assert property (p_sub_trap) else $error("overflow not trapped");
  property p_sw_align;
    @(posedge clk_i) disable iff (rst_i)
      s_exec(OP_SW, ea[1:0] != 2'h0) |=> exc_reg == EXC_ADDR && !xlat_req_o.valid;
  endproperty
  a_sw_align: assert property (p_sw_align) else $error("misaligned word store");
  property p_swl_noalign;
    @(posedge clk_i) disable iff (rst_i) s_exec(OP_SWL, 1'b1) |=> xlat_req_o.valid && !done_reg;
  endproperty
  a_swl_noalign: assert property (p_swl_noalign) else $error("partial store refused");
  property p_cop_resv;
    @(posedge clk_i) disable iff (rst_i)
      s_exec(OP_SWC, cop == COP_RESERVED || cop == COP_SYSTEM) |=> exc_reg == EXC_RESV;
  endproperty
  a_cop_resv: assert property (p_cop_resv) else $error("reserved cop not refused");
  property p_cop_unusable;
    @(posedge clk_i) disable iff (rst_i)
      s_exec(OP_SWC, cop != COP_SYSTEM && cop != COP_RESERVED && !cop_en[cop])
      |=> exc_reg == EXC_COP_UNUSABLE && !cop_req_o;
  endproperty
  a_cop_unusable: assert property (p_cop_unusable) else $error("disabled cop used");
  property p_xlat_fault;
    @(posedge clk_i) disable iff (rst_i)
      state_reg == S_XLAT && xlat_rsp_i.ack && xlat_rsp_i.fault != XF_NONE
      |=> exc_reg != EXC_NONE ##1 !mem_req_o.valid;
  endproperty
  a_xlat_fault: assert property (p_xlat_fault) else $error("fault not reported");
  property p_le_mem_off;
    @(posedge clk_i) disable iff (rst_i) mem_req_o.valid && !mem_be |-> mem_req_o.paddr[1:0] == 0;
  endproperty
  a_le_mem_off: assert property (p_le_mem_off) else $error("lane offset wrong");
  property p_lane_code;
    @(posedge clk_i) disable iff (rst_i)
      $rose(mem_req_o.valid) && op == OP_SWL |-> mem_req_o.byte_code == lane_byte;
  endproperty
  a_lane_code: assert property (p_lane_code) else $error("byte count code wrong");
  property p_store_hold;
    @(posedge clk_i) disable iff (rst_i)
      mem_req_o.valid && !mem_rsp_i.ack |=> mem_req_o.valid && $stable(mem_req_o.data);
  endproperty
  a_store_hold: assert property (p_store_hold) else $error("store dropped early");
endmodule : sub_store_exec

//--- tb/sws_far_model.sv
// far-side model: translation, memory and coprocessor answers
`timescale 1ns/1ps
module sws_far_model
  import sws_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sws_pkg::xlat_req_t xlat_req_i,
  output sws_pkg::xlat_rsp_t xlat_rsp_o,
  input wire sws_pkg::mem_req_t mem_req_i,
  output sws_pkg::mem_rsp_t mem_rsp_o,
  input wire logic cop_req_i,
  input wire logic [1:0] cop_sel_i,
  output logic cop_ack_o,
  output logic [31:0] cop_data_o,
  input wire logic [1:0] fault_i,
  input wire logic berr_i,
  input wire logic slow_i,
  output sws_pkg::mem_req_t seen_o,
  output logic [1:0] seen_sel_o,
  output logic [7:0] mem_count_o
);
  logic [2:0] wait_cnt;
  logic x_ack;
  logic m_ack;
  logic rdy;
  logic [31:0] cop_word;
  assign rdy = wait_cnt >= (slow_i ? 3'h3 : 3'h0);
  assign cop_word = 32'hc3a50f00 | {30'h0, cop_sel_i};
  // wait counter restarts after each answer so slow mode stalls every phase
  always_ff @(posedge clk_i) begin
    if (rst_i || x_ack || m_ack || cop_ack_o) begin
      wait_cnt <= 3'h0;
    end else if ((xlat_req_i.valid || mem_req_i.valid || cop_req_i) && wait_cnt != 3'h7) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
  // one-cycle answers, never two in a row for one request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x_ack <= 1'b0;
      m_ack <= 1'b0;
      cop_ack_o <= 1'b0;
    end else begin
      x_ack <= xlat_req_i.valid && rdy && !x_ack;
      m_ack <= mem_req_i.valid && rdy && !m_ack;
      cop_ack_o <= cop_req_i && rdy && !cop_ack_o;
    end
  end
  // outside an answer the lines show inverted junk, not a stale value
  assign xlat_rsp_o.ack = x_ack;
  assign xlat_rsp_o.fault = xfault_t'(x_ack ? fault_i : ~fault_i);
  assign xlat_rsp_o.paddr = x_ack ? xlat_req_i.vaddr[35:0] : ~xlat_req_i.vaddr[35:0];
  assign mem_rsp_o.ack = m_ack;
  assign mem_rsp_o.bus_err = m_ack ? berr_i : ~berr_i;
  assign cop_data_o = cop_ack_o ? cop_word : ~cop_word;
  // capture of what memory accepted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_count_o <= 8'h00;
      seen_o <= '0;
      seen_sel_o <= 2'h0;
    end else begin
      if (m_ack) begin
        seen_o <= mem_req_i;
        mem_count_o <= mem_count_o + 8'h01;
      end
      if (cop_ack_o) begin
        seen_sel_o <= cop_sel_i;
      end
    end
  end
endmodule : sws_far_model

//--- tb/subtract_and_word_store_exec_tb.sv
// testbench: register-driven subtract and store sequences
`timescale 1ns/1ps
module subtract_and_word_store_exec_tb;
  import sws_pkg::*;
  logic clk, rst, cyc, stb, we, ack, berr, slow, cop_req, cop_ack, cb;
  logic [7:0] adr, mcount, n0;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, rdata, st, cop_data;
  logic [63:0] v;
  logic [1:0] cop_sel, fault, seen_sel;
  xlat_req_t xq;
  xlat_rsp_t xr;
  mem_req_t mq, seen;
  mem_rsp_t mr;
  int num_errors, check_count, cycles, f, k;
  sub_store_exec u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .xlat_req_o(xq), .xlat_rsp_i(xr), .mem_req_o(mq), .mem_rsp_i(mr), .cop_req_o(cop_req),
    .cop_sel_o(cop_sel), .cop_ack_i(cop_ack), .cop_data_i(cop_data));
  sws_far_model u_far (.clk_i(clk), .rst_i(rst), .xlat_req_i(xq), .xlat_rsp_o(xr),
    .mem_req_i(mq), .mem_rsp_o(mr), .cop_req_i(cop_req), .cop_sel_i(cop_sel),
    .cop_ack_o(cop_ack), .cop_data_o(cop_data), .fault_i(fault), .berr_i(berr),
    .slow_i(slow), .seen_o(seen), .seen_sel_o(seen_sel), .mem_count_o(mcount));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string name, input logic [63:0] seen_v, input logic [63:0] exp_v);
    check_count++;
    if (seen_v !== exp_v) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask : chk
  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdata = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic set_reg(input logic [4:0] r, input logic [63:0] x);
    wb(1'b1, ADR_GPR_LO, x[31:0]);
    wb(1'b1, ADR_GPR_HI, x[63:32]);
    wb(1'b1, ADR_GPR_ACC, {26'h0, 1'b1, r});
  endtask : set_reg
  task automatic get_reg(input logic [4:0] r);
    wb(1'b1, ADR_GPR_ACC, {27'h0, r});
    wb(1'b0, ADR_GPR_LO, 32'h0);
    v[31:0] = rdata;
    wb(1'b0, ADR_GPR_HI, 32'h0);
    v[63:32] = rdata;
  endtask : get_reg
  // start a command and poll status until done, bounded
  task automatic run(input logic [2:0] op, input logic [4:0] d, input logic [4:0] a,
                     input logic [4:0] b, input logic [1:0] c);
    wb(1'b1, ADR_CMD, {12'h0, c, b, a, d, op});
    for (int i = 0; i < 50; i++) begin
      wb(1'b0, ADR_STATUS, 32'h0);
      if (rdata[STAT_DONE] === 1'b1) break;
    end
    st = rdata;
    if (rdata[STAT_DONE] !== 1'b1) num_errors++; // poll limit ran out
  endtask : run
  function automatic logic [63:0] swl_exp(input logic [31:0] r, input logic [2:0] b,
                                          input logic c);
    logic [1:0] by;
    logic [31:0] w;
    by = b[1:0] ^ {c, c};
    w = r >> (8 * (3 - by));
    return (b[2] ^ c) ? {w, 32'h0} : {32'h0, w};
  endfunction : swl_exp
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hf; dat_w = 32'h0;
    fault = 2'h0; berr = 1'b0; slow = 1'b0; num_errors = 0; check_count = 0; cycles = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl reset", rdata, 64'h01);
    wb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", rdata, 64'h0);
    set_reg(1, 64'h5); set_reg(2, 64'h7); set_reg(4, 64'h7fffffff); set_reg(5, '1);
    run(OP_NONTRAPPING_SUBTRACT, 3, 1, 2, 0);
    get_reg(3);
    chk("nontrapping_subtract", v, 64'hffffffff_fffffffe);
    run(OP_NONTRAPPING_SUBTRACT, 6, 4, 5, 0);
    chk("nontrapping_subtract exc", st[5:2], EXC_NONE);
    get_reg(6);
    chk("nontrapping_subtract wrap", v, 64'hffffffff_80000000);
    run(OP_SUB, 3, 4, 5, 0);
    chk("sub exc", st[5:2], EXC_OVF);
    get_reg(3);
    chk("sub keep", v, 64'hffffffff_fffffffe);
    set_reg(6, 64'h110); set_reg(7, 64'h11223344);
    wb(1'b1, ADR_OFFSET, 32'hfff8);
    run(OP_SW, 0, 6, 7, 0);
    wb(1'b0, ADR_VADDR_LO, 32'h0);
    chk("vaddr", rdata, 64'h108);
    chk("sw addr", seen.paddr, 36'h108);
    chk("sw data", seen.data, 64'h11223344);
    n0 = mcount;
    wb(1'b1, ADR_OFFSET, 32'hfffa);
    run(OP_SW, 0, 6, 7, 0);
    chk("sw align", st[5:2], EXC_ADDR);
    chk("sw none", mcount, n0);
    wb(1'b1, ADR_OFFSET, 32'hfff8);
    for (f = 1; f < 4; f++) begin
      fault <= f[1:0];
      run(OP_SW, 0, 6, 7, 0);
      chk("sw tlb", st[5:2], EXC_ADDR + f);
    end
    fault <= 2'h0;
    berr <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h21);
    wb(1'b1, ADR_OFFSET, 32'hfff4);
    run(OP_SWC, 0, 6, 0, 1);
    chk("swc bus", st[5:2], EXC_BUS);
    berr <= 1'b0;
    slow <= 1'b1;
    run(OP_SWC, 0, 6, 0, 1);
    chk("swc data", seen.data, {32'hc3a50f01, 32'h0});
    chk("swc sel", seen_sel, 2'h1);
    run(OP_SWC, 0, 6, 0, 0);
    chk("swc cop0", st[5:2], EXC_RESV);
    run(OP_SWC, 0, 6, 0, 3);
    chk("swc cop3", st[5:2], EXC_RESV);
    run(OP_SWC, 0, 6, 0, 2);
    chk("swc off", st[5:2], EXC_COP_UNUSABLE);
    wb(1'b1, ADR_OFFSET, 32'hfff6);
    run(OP_SWC, 0, 6, 0, 1);
    chk("swc align", st[5:2], EXC_ADDR);
    // every byte position in both cpu orders
    for (k = 0; k < 16; k++) begin
      cb = k[3];
      wb(1'b1, ADR_CTRL, cb ? 32'h07 : 32'h01);
      wb(1'b1, ADR_OFFSET, 32'hfff0 + k[2:0]);
      slow <= k[0];
      run(OP_SWL, 0, 6, 7, 0);
      chk("swl exc", st[5:2], EXC_NONE);
      chk("swl data", seen.data, swl_exp(32'h11223344, k[2:0], cb));
      chk("swl code", seen.byte_code, k[1:0] ^ {cb, cb});
      chk("swl addr", seen.paddr, {33'h20, cb ? k[2:0] : {k[2], 2'b00}});
    end
    wb(1'b1, ADR_CTRL, 32'h09);
    wb(1'b1, ADR_OFFSET, 32'hfff5);
    run(OP_SWL, 0, 6, 7, 0);
    chk("swl reverse", seen.paddr, 36'h100);
    tally_and_finish();
  end
endmodule : subtract_and_word_store_exec_tb
